/* File: hdl/conv_clock_gen.sv */
`timescale 1ns/1ps
module conv_clock_gen
  import sar_adc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       oscClk,
  input  wire logic       srcBus,
  input  wire logic [2:0] divSel,
  output logic            tick
);

  logic       oscMeta_q;
  logic       oscSync_q;
  logic       oscLast_q;
  logic [3:0] cnt_q;
  logic       tick_q;

  function automatic logic [3:0] divTop(input logic [2:0] sel);
    logic [3:0] t;
    t = 4'hF;
    unique case (sel)
      3'h0:    t = 4'h0;
      3'h1:    t = 4'h1;
      3'h2:    t = 4'h3;
      3'h3:    t = 4'h7;
      default: t = 4'hF;
    endcase
    return t;
  endfunction : divTop

  wire logic [3:0] top     = divTop(divSel);
  // Bus clock counts every mclk edge, oscillator clock counts its rising edges
  wire logic       srcEdge = srcBus | (oscSync_q & ~oscLast_q); // [R21]
  wire logic       wrap    = srcEdge & (cnt_q >= top);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      oscMeta_q <= 1'b0;
      oscSync_q <= 1'b0;
      oscLast_q <= 1'b0;
      cnt_q     <= 4'h0;
      tick_q    <= 1'b0;
    end else begin
      oscMeta_q <= oscClk;
      oscSync_q <= oscMeta_q;
      oscLast_q <= oscSync_q;
      tick_q    <= wrap;
      if (wrap)
        cnt_q <= 4'h0;
      else if (srcEdge)
        cnt_q <= cnt_q + 4'h1;
    end
  end

  assign tick = tick_q;

  tickOnlyOnEdge_a: assert property (@(posedge mclk) disable iff (!nrst) // [R21]
    tick |-> $past(srcEdge)) else $error("converter tick without source edge");

endmodule : conv_clock_gen

/* File: hdl/sar_adc_pkg.sv */
package sar_adc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry and answers
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0]  OFF_STATUS   = 8'h00;
  localparam logic [7:0]  OFF_RES_HIGH = 8'h04;
  localparam logic [7:0]  OFF_RES_LOW  = 8'h08;
  localparam logic [7:0]  OFF_CLOCK    = 8'h0C;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int          STAT_DONE_BIT = 7;
  localparam int          STAT_IEN_BIT  = 6;
  localparam int          STAT_CONT_BIT = 5;
  localparam int          CHAN_W        = 5;
  localparam int          CLK_DIV_LSB   = 5;
  localparam int          CLK_SRC_BIT   = 4;
  localparam int          CLK_FMT_LSB   = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and codes
  localparam logic [4:0]  CHAN_OFF      = 5'h1F;
  localparam logic [4:0]  CHAN_RESET    = 5'h1F;
  localparam logic [4:0]  NUM_PINS      = 5'h08;
  localparam logic [2:0]  DIV_RESET     = 3'h0;
  localparam logic        SRC_RESET     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Converter timing, in converter clock ticks
  localparam int          RES_W         = 10;
  localparam logic [3:0]  SAMPLE_LAST   = 4'h4;
  localparam logic [3:0]  MSB_INDEX     = 4'h9;
  localparam logic [9:0]  MSB_TRIAL     = 10'h200;
  localparam logic [4:0]  CONV_TICKS    = 5'h10;

  typedef enum logic [1:0] {
    FMT_LEFT   = 2'b00,
    FMT_RIGHT  = 2'b01,
    FMT_SIGNED = 2'b10,
    FMT_TRUNC  = 2'b11
  } fmt_t;

  localparam fmt_t        FMT_RESET     = FMT_LEFT;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b11,
    ST_FINISH  = 2'b10
  } sar_state_t;

endpackage : sar_adc_pkg

/* File: hdl/sar_adc_sequencer.sv */
// Summary of operation
// R01 - Selected pin forced to analog input
// R02 - Selected pin ignores port writes, reads zero
// R03 - Full scale gives 3FF, low gives 000
// R04 - Status write starts conversion, sixteen ticks
// R05 - Software sets converter clock near 1 MHz
// R06 - Continuous mode overwrites result every conversion
// R07 - Continuous flag sets once, cleared by access
// R08 - Single mode converts once per status write
// R09 - Two-bit field picks one of four formats
// R10 - Left format: eight MSBs high, two low
// R11 - High read locks low until low read
// R12 - Right format: two MSBs high, eight low
// R13 - Signed format inverts result MSB
// R14 - Truncation: eight MSBs low, no lock
// R15 - Interrupt enable raises request per conversion
// R16 - Converter keeps running in wait mode
// R17 - Software powers down before wait if unneeded
// R18 - Stop aborts conversion, resumes after exit
// R19 - Software discards first result after stop
// R20 - Channel all ones powers converter off
// R21 - Source select picks bus or oscillator
// R22 - Continuous mode updates results each conversion
// R23 - Status write mid-conversion restarts on new channel
// R24 - Results change only at conversion end
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module sar_adc_sequencer
  import sar_adc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              oscClk,
  input  wire logic              stopMode,
  input  wire logic              compIn,
  output logic [RES_W-1:0]       dacCode,
  output logic [CHAN_W-1:0]      analogSel,
  output logic                   convPowerOn,
  output logic                   irq,
  input  wire logic [7:0]        portOut,
  input  wire logic [7:0]        portDir,
  input  wire logic [7:0]        pinIn,
  output logic [7:0]             pinOut,
  output logic [7:0]             pinOe,
  output logic [7:0]             portReadData
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return (a == OFF_STATUS) || (a == OFF_RES_HIGH) || (a == OFF_RES_LOW) ||
           (a == OFF_CLOCK);
  endfunction : isMapped

  function automatic logic [7:0] chanMask(input logic [CHAN_W-1:0] c);
    logic [7:0] m;
    m = 8'h00;
    if (c < NUM_PINS)
      m = 8'h01 << c[2:0];
    return m;
  endfunction : chanMask

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic              awHeld_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic              wHeld_q;
  logic [DATA_W-1:0] wData_q;
  logic              wByte0_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        rresp_q;

  logic              ien_q;
  logic              cont_q;
  logic [CHAN_W-1:0] chan_q;
  logic [2:0]        div_q;
  logic              src_q;
  fmt_t              fmt_q;
  logic              doneFlag_q;
  logic              firstDone_q;
  logic              irq_q;
  logic              lock_q;
  logic [7:0]        resHigh_q;
  logic [7:0]        resLow_q;
  logic              stopLast_q;
  logic              aborted_q;
  logic              convPowerOn_q;
  logic [7:0]        pinMeta_q;
  logic [7:0]        pinSync_q;
  logic [7:0]        pinOut_q;
  logic [7:0]        pinOe_q;
  logic [7:0]        portRead_q;
  logic              compMeta_q;
  logic              compSync_q;

  logic              convTick;
  logic              convBusy;
  logic              donePulse;
  logic [RES_W-1:0]  convResult;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  wire logic doWrite  = awHeld_q & wHeld_q & ~bvalid_q;
  wire logic awTake   = awvalid & awready_q;
  wire logic wTake    = wvalid & wready_q;
  wire logic awHeldD  = awHeld_q ? ~doWrite : awTake;
  wire logic wHeldD   = wHeld_q ? ~doWrite : wTake;
  wire logic statusWr = doWrite & wByte0_q & (awAddr_q == OFF_STATUS);
  wire logic clockWr  = doWrite & wByte0_q & (awAddr_q == OFF_CLOCK);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      awHeld_q  <= 1'b0;
      wHeld_q   <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awAddr_q  <= 8'h00;
      wData_q   <= 32'h0000_0000;
      wByte0_q  <= 1'b0;
    end else begin
      awHeld_q  <= awHeldD;
      wHeld_q   <= wHeldD;
      awready_q <= ~awHeldD;
      wready_q  <= ~wHeldD;
      if (awTake)
        awAddr_q <= awaddr;
      if (wTake) begin
        wData_q  <= wdata;
        wByte0_q <= wstrb[0];
      end
      if (doWrite) begin
        bvalid_q <= 1'b1;
        bresp_q  <= isMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel and read side effects

  wire logic rdTake   = arvalid & arready_q;
  wire logic rvalidD  = rvalid_q ? ~rready : rdTake;
  wire logic highRead = rdTake & (araddr == OFF_RES_HIGH);
  wire logic lowRead  = rdTake & (araddr == OFF_RES_LOW);
  wire logic dataRead = highRead | lowRead;
  wire logic fmtTrunc = (fmt_q == FMT_TRUNC);

  wire logic [DATA_W-1:0] statusWord = {24'h00_0000, doneFlag_q, ien_q, cont_q, chan_q};
  wire logic [DATA_W-1:0] clockWord  = {24'h00_0000, div_q, src_q, fmt_q, 2'b00};
  wire logic [DATA_W-1:0] readWord   =
      (araddr == OFF_STATUS)   ? statusWord :
      (araddr == OFF_RES_HIGH) ? {24'h00_0000, resHigh_q} :
      (araddr == OFF_RES_LOW)  ? {24'h00_0000, resLow_q} :
      (araddr == OFF_CLOCK)    ? clockWord : 32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else begin
      arready_q <= ~rvalidD;
      rvalid_q  <= rvalidD;
      if (rdTake) begin
        rdata_q <= readWord;
        rresp_q <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ien_q  <= 1'b0;
      cont_q <= 1'b0;
      chan_q <= CHAN_RESET;
      div_q  <= DIV_RESET;
      src_q  <= SRC_RESET;
      fmt_q  <= FMT_RESET;
    end else begin
      if (statusWr) begin
        ien_q  <= wData_q[STAT_IEN_BIT];
        cont_q <= wData_q[STAT_CONT_BIT];
        chan_q <= wData_q[CHAN_W-1:0];
      end
      if (clockWr) begin
        div_q <= wData_q[CLK_DIV_LSB+2:CLK_DIV_LSB];
        src_q <= wData_q[CLK_SRC_BIT];
        fmt_q <= fmt_t'(wData_q[CLK_FMT_LSB+1:CLK_FMT_LSB]); // [R09]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing

  wire logic newOff  = (wData_q[CHAN_W-1:0] == CHAN_OFF);
  wire logic convOff = (chan_q == CHAN_OFF);
  wire logic resume  = stopLast_q & ~stopMode & ~convOff & (cont_q | aborted_q); // [R18]
  wire logic engHalt = stopMode | (statusWr ? newOff : convOff); // [R18] [R20]
  wire logic engStart = (statusWr & ~newOff) | resume; // [R04] [R08] [R23]

  conv_clock_gen uClock (
    .mclk   (mclk),
    .nrst   (nrst),
    .oscClk (oscClk),
    .srcBus (src_q),
    .divSel (div_q),
    .tick   (convTick)
  );

  sar_engine uEngine (
    .mclk      (mclk),
    .nrst      (nrst),
    .start     (engStart),
    .halt      (engHalt),
    .cont      (cont_q),
    .tick      (convTick),
    .compHigh  (compSync_q),
    .busy      (convBusy),
    .donePulse (donePulse),
    .dacCode   (dacCode),
    .result    (convResult)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result formatting, interlock, flag and request

  wire logic [7:0] fmtHigh =
      (fmt_q == FMT_LEFT)   ? convResult[9:2] : // [R10]
      (fmt_q == FMT_RIGHT)  ? {6'h00, convResult[9:8]} : // [R12]
      (fmt_q == FMT_SIGNED) ? {~convResult[9], convResult[8:2]} : 8'h00; // [R13] [R14]
  wire logic [7:0] fmtLow =
      (fmt_q == FMT_RIGHT)  ? convResult[7:0] : // [R12]
      fmtTrunc              ? convResult[9:2] : // [R14]
      {convResult[1:0], 6'h00}; // [R10]

  wire logic storeOk   = donePulse & (~lock_q | fmtTrunc); // [R11] [R24]
  wire logic clearDone = statusWr | dataRead;
  wire logic setDone   = donePulse & ~ien_q & (~cont_q | ~firstDone_q); // [R07] [R15]

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      resHigh_q   <= 8'h00;
      resLow_q    <= 8'h00;
      lock_q      <= 1'b0;
      doneFlag_q  <= 1'b0;
      firstDone_q <= 1'b0;
      irq_q       <= 1'b0;
      stopLast_q  <= 1'b0;
      aborted_q   <= 1'b0;
    end else begin
      if (storeOk) begin
        resHigh_q <= fmtHigh; // [R06] [R22]
        resLow_q  <= fmtLow;
      end
      lock_q      <= ~fmtTrunc & (highRead | (lock_q & ~lowRead)); // [R11] [R14]
      doneFlag_q  <= setDone | (doneFlag_q & ~clearDone); // [R07]
      firstDone_q <= donePulse | (firstDone_q & ~statusWr); // [R07]
      // Wait mode gates nothing here, so this request can wake the core
      irq_q       <= (donePulse & ien_q) | (irq_q & ~clearDone); // [R15] [R16]
      stopLast_q  <= stopMode;
      aborted_q   <= stopMode & (aborted_q | convBusy | (statusWr & ~newOff));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared port pins and analog inputs

  wire logic [7:0] selMask = chanMask(chan_q);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pinMeta_q     <= 8'h00;
      pinSync_q     <= 8'h00;
      compMeta_q    <= 1'b0;
      compSync_q    <= 1'b0;
      pinOut_q      <= 8'h00;
      pinOe_q       <= 8'h00;
      portRead_q    <= 8'h00;
      convPowerOn_q <= 1'b0;
    end else begin
      pinMeta_q     <= pinIn;
      pinSync_q     <= pinMeta_q;
      compMeta_q    <= compIn;
      compSync_q    <= compMeta_q;
      pinOut_q      <= portOut & ~selMask; // [R02]
      pinOe_q       <= portDir & ~selMask; // [R01]
      portRead_q    <= pinSync_q & ~selMask; // [R02]
      convPowerOn_q <= ~convOff; // [R20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign awready      = awready_q;
  assign wready       = wready_q;
  assign bvalid       = bvalid_q;
  assign bresp        = bresp_q;
  assign arready      = arready_q;
  assign rvalid       = rvalid_q;
  assign rdata        = rdata_q;
  assign rresp        = rresp_q;
  assign analogSel    = chan_q;
  assign convPowerOn  = convPowerOn_q;
  assign irq          = irq_q;
  assign pinOut       = pinOut_q;
  assign pinOe        = pinOe_q;
  assign portReadData = portRead_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence lockedNoLowRead;
    lock_q && !lowRead && !fmtTrunc;
  endsequence

  sequence resultDone;
    donePulse && !lock_q;
  endsequence

  pinOverride_a: assert property ((chan_q < NUM_PINS) |=> // [R01]
    !pinOe[$past(chan_q[2:0])]) else $error("selected pin still driven");

  portReadZero_a: assert property ((chan_q < NUM_PINS) |=> // [R02]
    !portReadData[$past(chan_q[2:0])]) else $error("selected pin reads nonzero");

  startOnWrite_a: assert property ((statusWr && !newOff && !stopMode) |=> // [R04]
    convBusy) else $error("status write did not start conversion");

  lowHeldLock_a: assert property (lockedNoLowRead |=> $stable(resLow_q)) // [R11]
    else $error("low result changed while locked");

  rightJust_a: assert property ((resultDone and (fmt_q == FMT_RIGHT)) |=> // [R12]
    (resHigh_q == {6'h00, $past(convResult[9:8])}) && (resLow_q == $past(convResult[7:0])))
    else $error("right justified layout wrong");

  signedMsb_a: assert property ((resultDone and (fmt_q == FMT_SIGNED)) |=> // [R13]
    (resHigh_q[7] != $past(convResult[9]))) else $error("signed msb not inverted");

  truncLayout_a: assert property ((donePulse && fmtTrunc) |=> // [R14]
    (resHigh_q == 8'h00) && (resLow_q == $past(convResult[9:2])))
    else $error("truncated layout wrong");

  irqRaise_a: assert property ((donePulse && ien_q) |=> irq ##1 // [R15]
    (irq || $past(clearDone))) else $error("interrupt request not raised");

  doneFlag_a: assert property ((donePulse && !ien_q && !cont_q) |=> // [R07]
    doneFlag_q) else $error("completion flag not set");

  noPartial_a: assert property (!donePulse |=> $stable(resHigh_q)) // [R24]
    else $error("result changed without completion");

  powerOff_a: assert property ((chan_q == CHAN_OFF) |=> !convPowerOn) // [R20]
    else $error("converter powered with channel off");

endmodule : sar_adc_sequencer

/* File: hdl/sar_engine.sv */
`timescale 1ns/1ps
module sar_engine
  import sar_adc_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             start,
  input  wire logic             halt,
  input  wire logic             cont,
  input  wire logic             tick,
  input  wire logic             compHigh,
  output logic                  busy,
  output logic                  donePulse,
  output logic [RES_W-1:0]      dacCode,
  output logic [RES_W-1:0]      result
);

  sar_state_t       state_q;
  logic [3:0]       cnt_q;
  logic [3:0]       bitIdx_q;
  logic [RES_W-1:0] code_q;
  logic [RES_W-1:0] result_q;
  logic             done_q;
  logic [4:0]       tickCnt_q;

  wire logic [RES_W-1:0] curBit  = 10'h001 << bitIdx_q;
  wire logic [RES_W-1:0] nextBit = curBit >> 1;
  // Keep the trial bit while the input is at or above the trial level
  wire logic [RES_W-1:0] decided = compHigh ? code_q : (code_q & ~curBit); // [R03]

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_q  <= ST_IDLE;
      cnt_q    <= 4'h0;
      bitIdx_q <= MSB_INDEX;
      code_q   <= 10'h000;
      result_q <= 10'h000;
      done_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (halt) begin
        state_q <= ST_IDLE; // [R18] [R20]
      end else if (start) begin
        state_q <= ST_SAMPLE; // [R04] [R23]
        cnt_q   <= 4'h0;
        code_q  <= 10'h000;
      end else if (tick) begin
        unique case (state_q)
          ST_IDLE: begin
          end
          ST_SAMPLE: begin
            if (cnt_q == SAMPLE_LAST) begin
              state_q  <= ST_CONVERT;
              bitIdx_q <= MSB_INDEX;
              code_q   <= MSB_TRIAL;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
          ST_CONVERT: begin
            code_q   <= decided | nextBit;
            bitIdx_q <= bitIdx_q - 4'h1;
            if (bitIdx_q == 4'h0)
              state_q <= ST_FINISH;
          end
          ST_FINISH: begin
            result_q <= code_q; // [R24]
            done_q   <= 1'b1;
            cnt_q    <= 4'h0;
            code_q   <= 10'h000;
            state_q  <= cont ? ST_SAMPLE : ST_IDLE; // [R06] [R08] [R22]
          end
        endcase
      end
    end
  end

  assign busy      = (state_q != ST_IDLE);
  assign donePulse = done_q;
  assign dacCode   = code_q;
  assign result    = result_q;

  // Ticks counted since the conversion began, for checking only
  always_ff @(posedge mclk) begin
    if (!nrst || start || (state_q == ST_IDLE) || (tick && state_q == ST_FINISH))
      tickCnt_q <= 5'h00;
    else if (tick)
      tickCnt_q <= tickCnt_q + 5'h01;
  end

  convLength_a: assert property (@(posedge mclk) disable iff (!nrst) // [R04]
    (tick && state_q == ST_FINISH && !halt && !start) |-> (tickCnt_q == CONV_TICKS - 5'h01))
    else $error("conversion did not take sixteen converter ticks");

  haltAborts_a: assert property (@(posedge mclk) disable iff (!nrst) // [R18]
    halt |=> !busy && !donePulse) else $error("halt did not abort conversion");

endmodule : sar_engine

/* File: tb/analog_core_model.sv */
`timescale 1ns/1ps
module analog_core_model
  import sar_adc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic [CHAN_W-1:0] analogSel,
  input  wire logic [RES_W-1:0]  dacCode,
  input  wire logic [RES_W-1:0]  level,
  output logic                   compIn
);
  initial compIn = 1'b0;
  // Reference channels give full scale and zero; off or unused toggles each cycle
  always @(posedge mclk) begin
    if (analogSel == 5'h1D) compIn <= 1'b1;
    else if (analogSel == 5'h1E) compIn <= (dacCode == 10'h000);
    else if (analogSel < NUM_PINS) compIn <= (level >= dacCode);
    else compIn <= ~compIn;
  end
endmodule : analog_core_model

/* File: tb/sar_adc_sequencer_tb.sv */
`timescale 1ns/1ps
module sar_adc_sequencer_tb;
  import sar_adc_pkg::*;
  typedef struct {logic [31:0] e; logic [31:0] m;} note_t;
  logic        mclk = 1'b0, nrst = 1'b0, oscClk = 1'b0, stopMode = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, portOut = 8'h00, portDir = 8'h00, pinIn = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, compIn, convPowerOn, irq;
  logic [9:0]  dacCode, level = 10'h000, v;
  logic [4:0]  analogSel;
  logic [7:0]  pinOut, pinOe, portReadData, p;
  int          fail_count = 0, cmp_count = 0, seed = 32'hF433075D, n;
  note_t       q[$];
  note_t       nt;

  always #4 mclk = ~mclk;
  always #13 oscClk = ~oscClk;

  sar_adc_sequencer uut (.mclk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .oscClk, .stopMode, .compIn, .dacCode, .analogSel, .convPowerOn, .irq, .portOut,
    .portDir, .pinIn, .pinOut, .pinOe, .portReadData);
  analog_core_model core (.mclk, .analogSel, .dacCode, .level, .compIn);

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic bound(input int k);
    if (k > 200) begin
      fail_count++;
      $display("[FAIL] wait expected answer seen none");
      finish_test();
    end
  endtask : bound

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    int k;
    k = 0;
    q.push_back('{{30'h0, r}, 32'h3});
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      bound(k++);
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    int k;
    k = 0;
    q.push_back('{e, m});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      bound(k++);
    end while (rvalid !== 1'b1);
    got = rdata;
    rready <= 1'b0;
    @(posedge mclk);
  endtask : rd

  task automatic wait_done;
    int k;
    k = 0;
    do begin
      rd(OFF_STATUS, 32'h0, 32'h0);
      bound(4 * k++);
    end while (got[STAT_DONE_BIT] !== 1'b1);
  endtask : wait_done

  function automatic logic [31:0] hi(input int f, input logic [9:0] x);
    case (f)
      0: return {24'h0, x[9:2]};
      1: return {30'h0, x[9:8]};
      2: return {24'h0, ~x[9], x[8:2]};
      default: return 32'h0;
    endcase
  endfunction : hi

  function automatic logic [31:0] lo(input int f, input logic [9:0] x);
    return f == 1 ? {24'h0, x[7:0]} : f == 3 ? {24'h0, x[9:2]} : {24'h0, x[1:0], 6'h00};
  endfunction : lo

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if ((rvalid && rready) || (bvalid && bready)) begin
      nt = q.pop_front();
      if (nt.m != 32'h0) chk("bus", nt.e, (rvalid ? rdata : {30'h0, bresp}) & nt.m);
    end
  end

  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(OFF_STATUS, 32'h1F, 32'hFF);
    rd(OFF_CLOCK, 32'h0, 32'hFF);
    chk("power", 32'h0, {31'h0, convPowerOn});
    wr(8'h10, 8'h00, RESP_SLVERR);
    $display("reset and map test done");
    for (int f = 0; f < 4; f++) begin
      v = 10'($random(seed));
      level <= v;
      wr(OFF_CLOCK, (f[0] ? 8'h20 : 8'h50) | 8'(f << 2), RESP_OKAY);
      wr(OFF_STATUS, {3'b000, 5'(f)}, RESP_OKAY);
      wait_done();
      rd(OFF_RES_HIGH, hi(f, v), 32'hFF);
      rd(OFF_RES_LOW, lo(f, v), 32'hFF);
    end
    wr(OFF_CLOCK, 8'h50, RESP_OKAY);
    for (int c = 0; c < 2; c++) begin
      wr(OFF_STATUS, 8'(5'h1D + c), RESP_OKAY);
      wait_done();
      rd(OFF_RES_HIGH, c ? 32'h0 : 32'hFF, 32'hFF);
      rd(OFF_RES_LOW, c ? 32'h0 : 32'hC0, 32'hFF);
    end
    $display("format and reference test done");
    level <= 10'h155;
    wr(OFF_STATUS, 8'h00, RESP_OKAY);
    wait_done();
    rd(OFF_RES_HIGH, 32'h55, 32'hFF);
    level <= 10'h2AA;
    wr(OFF_STATUS, 8'h00, RESP_OKAY);
    wait_done();
    rd(OFF_RES_LOW, 32'h40, 32'hFF);
    rd(OFF_RES_HIGH, 32'h55, 32'hFF);
    rd(OFF_RES_LOW, 32'h40, 32'hFF);
    $display("interlock test done");
    wr(OFF_STATUS, 8'h20, RESP_OKAY);
    wait_done();
    level <= 10'h3FF;
    repeat (160) @(posedge mclk);
    rd(OFF_STATUS, 32'hA0, 32'hFF);
    rd(OFF_RES_HIGH, 32'hFF, 32'hFF);
    rd(OFF_RES_LOW, 32'hC0, 32'hFF);
    rd(OFF_STATUS, 32'h0, 32'h80);
    $display("continuous test done");
    level <= 10'h155;
    wr(OFF_STATUS, 8'h00, RESP_OKAY);
    stopMode <= 1'b1;
    repeat (150) @(posedge mclk);
    rd(OFF_STATUS, 32'h0, 32'hFF);
    stopMode <= 1'b0;
    wait_done();
    wr(OFF_STATUS, 8'h00, RESP_OKAY);
    wait_done();
    rd(OFF_RES_LOW, 32'h40, 32'hFF);
    wr(OFF_STATUS, 8'h1F, RESP_OKAY);
    $display("stop test done");
    p = 8'($random(seed));
    portOut <= p;
    portDir <= ~p;
    pinIn <= p;
    v = 10'($random(seed));
    level <= v;
    wr(OFF_STATUS, 8'h41, RESP_OKAY);
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge mclk);
      bound(n++);
    end
    rd(OFF_STATUS, 32'h41, 32'hFF);
    chk("pinOut", {24'h0, p & 8'hFD}, {24'h0, pinOut});
    chk("pinOe", {24'h0, ~p & 8'hFD}, {24'h0, pinOe});
    chk("portRead", {24'h0, p & 8'hFD}, {24'h0, portReadData});
    chk("power", 32'h1, {31'h0, convPowerOn});
    rd(OFF_RES_HIGH, hi(0, v), 32'hFF);
    chk("irq", 32'h0, {31'h0, irq});
    rd(OFF_RES_LOW, lo(0, v), 32'hFF);
    $display("interrupt and pin test done");
    finish_test();
  end
endmodule : sar_adc_sequencer_tb
